// ---- common/cpfs_pkg.sv ----
package cpfs_pkg;

    // ----------------------------------------
    // Widths and sizes
    // ----------------------------------------
    localparam int          PC_W        = 12;
    localparam int          PAGE_W      = 4;
    localparam int          STACK_DEPTH = 6;
    localparam int          CNT_W       = 3;
    localparam int          CPU_DIV     = 13;
    localparam int          DIV_W       = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [11:0] RESET_VECTOR = 12'hffe;
    localparam logic [3:0]  PAGE_RESET   = 4'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CTX_MAIN = 2'b00,
        CTX_IRQ  = 2'b01,
        CTX_NMI  = 2'b10
    } cpfs_ctx_t;

    typedef enum logic [2:0] {
        PCOP_HOLD   = 3'b000,
        PCOP_INC    = 3'b001,
        PCOP_BRANCH = 3'b010,
        PCOP_CALL   = 3'b011,
        PCOP_IRQ    = 3'b100,
        PCOP_NMI    = 3'b101,
        PCOP_RET    = 3'b110,
        PCOP_RETURN_FROM_INTERRUPT   = 3'b111
    } cpfs_pcop_t;

    typedef struct packed {
        logic carry_we;
        logic carry_val;
        logic zero_we;
        logic zero_val;
    } cpfs_flag_upd_t;

    typedef struct packed {
        logic carry;
        logic zero;
    } cpfs_flags_t;

endpackage

// ---- hdl/cpfs_cycle_div.sv ----
`timescale 1ns/1ps

module cpfs_cycle_div
    import cpfs_pkg::*;
#(
    parameter int DIV = CPU_DIV
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Cycle enable
    output logic      cpu_cycle_en
);

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] gap_reg;

    // ----------------------------------------
    // Divide by 13
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_reg      <= '0;
            cpu_cycle_en <= 1'b0;
        end
        else
        begin
            cpu_cycle_en <= (cnt_reg == DIV_W'(DIV - 1));
            if (cnt_reg == DIV_W'(DIV - 1))
                cnt_reg <= '0;
            else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Check helper: clocks since the last enable, starts at all ones so the first gap counts alike
    always_ff @(posedge clk)
    begin
        if (rst)
            gap_reg <= '1;
        else if (cpu_cycle_en)
            gap_reg <= '0;
        else
            gap_reg <= gap_reg + 1'b1;
    end

    a_div_period: assert property (@(posedge clk) disable iff (rst)
        cpu_cycle_en |-> gap_reg == DIV_W'(DIV - 1))
        else $error("Cycle enable period is not 13");

endmodule

// ---- hdl/cpfs_core_state.sv ----
`timescale 1ns/1ps

module cpfs_core_state
    import cpfs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Sequencer requests, sampled on CPU cycle; page write acts on any clock
    input  wire cpfs_pcop_t        pc_op,
    input  wire logic [7:0]        branch_offset,
    input  wire logic [PC_W-1:0]   irq_vector,
    input  wire logic [PC_W-1:0]   nmi_vector,
    input  wire logic              page_we,
    input  wire logic [PAGE_W-1:0] page_wdata,
    // ALU flag results
    input  wire cpfs_flag_upd_t    flag_upd,
    // Program memory address and state
    output logic [PC_W-1:0]        pc,
    output logic [PAGE_W-1:0]      prog_page,
    output cpfs_flags_t            cur_flags,
    output cpfs_ctx_t              ctx,
    output logic [CNT_W-1:0]       stack_depth,
    output logic                   cpu_cycle
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [PC_W-1:0]  stack_reg [DEPTH];
    logic [CNT_W-1:0] depth_reg;
    cpfs_ctx_t        prev_ctx_reg;
    cpfs_flags_t      flags_reg [3];
    logic             cyc_en;
    logic             is_push;
    logic             is_pop;
    logic [PC_W-1:0]  branch_sum;
    logic [PC_W-1:0]  pc_inc;

    cpfs_cycle_div #(
        .DIV (CPU_DIV)
    ) u_div (
        .clk          (clk),
        .rst          (rst),
        .cpu_cycle_en (cyc_en)
    );

    always_comb
    begin
        is_push    = cyc_en && (pc_op == PCOP_CALL || pc_op == PCOP_IRQ || pc_op == PCOP_NMI);
        is_pop     = cyc_en && (pc_op == PCOP_RET || pc_op == PCOP_RETURN_FROM_INTERRUPT);
        pc_inc     = pc + 1'b1;
        branch_sum = pc + {{(PC_W-8){branch_offset[7]}}, branch_offset};
    end

    // ----------------------------------------
    // Cycle enable out
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            cpu_cycle <= 1'b0;
        else
            cpu_cycle <= cyc_en;
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            pc <= RESET_VECTOR;
        else if (cyc_en)
        begin
            unique case (pc_op)
                PCOP_HOLD:   pc <= pc;
                PCOP_INC:    pc <= pc_inc;
                PCOP_BRANCH: pc <= branch_sum;
                PCOP_CALL:   pc <= irq_vector;
                PCOP_IRQ:    pc <= irq_vector;
                PCOP_NMI:    pc <= nmi_vector;
                PCOP_RET,
                PCOP_RETURN_FROM_INTERRUPT:   pc <= (depth_reg == '0) ? pc_inc : stack_reg[0];
            endcase
        end
    end

    // ----------------------------------------
    // Program page
    // ----------------------------------------
    // Counter wraps in 12 bits; software must move the page itself
    always_ff @(posedge clk)
    begin
        if (rst)
            prog_page <= PAGE_RESET;
        else if (page_we)
            prog_page <= page_wdata;
    end

    // ----------------------------------------
    // Return stack, only the counter is saved
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_lvl
            always_ff @(posedge clk)
            begin
                if (rst)
                    stack_reg[gi] <= '0;
                else if (is_push)
                    stack_reg[gi] <= (gi == 0) ? pc_inc : stack_reg[(gi == 0) ? 0 : gi - 1];
                else if (is_pop && depth_reg != '0)
                    stack_reg[gi] <= (gi == DEPTH - 1) ? '0 : stack_reg[(gi == DEPTH - 1) ? gi : gi + 1];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            depth_reg <= '0;
        else if (is_push && depth_reg != CNT_W'(DEPTH))
            depth_reg <= depth_reg + 1'b1;
        else if (is_pop && depth_reg != '0)
            depth_reg <= depth_reg - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            stack_depth <= '0;
        else if (is_push && depth_reg != CNT_W'(DEPTH))
            stack_depth <= depth_reg + 1'b1;
        else if (is_pop && depth_reg != '0)
            stack_depth <= depth_reg - 1'b1;
    end

    // ----------------------------------------
    // Context selection
    // ----------------------------------------
    // One saved context only: nesting NMI in IRQ restores IRQ, deeper is lost
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctx          <= CTX_NMI;
            prev_ctx_reg <= CTX_MAIN;
        end
        else if (cyc_en)
        begin
            if (pc_op == PCOP_IRQ && ctx == CTX_MAIN)
            begin
                prev_ctx_reg <= ctx;
                ctx          <= CTX_IRQ;
            end
            else if (pc_op == PCOP_NMI && ctx != CTX_NMI)
            begin
                prev_ctx_reg <= ctx;
                ctx          <= CTX_NMI;
            end
            else if (pc_op == PCOP_RETURN_FROM_INTERRUPT)
            begin
                ctx          <= prev_ctx_reg;
                prev_ctx_reg <= CTX_MAIN;
            end
        end
    end

    // ----------------------------------------
    // Banked flags
    // ----------------------------------------
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_flag
            always_ff @(posedge clk)
            begin
                if (rst)
                    flags_reg[gi] <= '0;
                else if (cyc_en && ctx == cpfs_ctx_t'(gi))
                begin
                    if (flag_upd.carry_we)
                        flags_reg[gi].carry <= flag_upd.carry_val;
                    if (flag_upd.zero_we)
                        flags_reg[gi].zero <= flag_upd.zero_val;
                end
            end
        end
    endgenerate

    // Mirror of the active pair, follows context change one edge later
    always_ff @(posedge clk)
    begin
        if (rst)
            cur_flags <= '0;
        else
            cur_flags <= flags_reg[ctx];
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_reset_vec: assert property (@(posedge clk) rst |=> pc == 12'hffe && ctx == CTX_NMI)
        else $error("Reset vector or context wrong");
    a_pc_inc: assert property (@(posedge clk) disable iff (rst)
        cyc_en && pc_op == PCOP_INC |=> pc == $past(pc) + 12'h001)
        else $error("Counter did not advance by one");
    a_branch_sum: assert property (@(posedge clk) disable iff (rst)
        cyc_en && pc_op == PCOP_BRANCH |=> pc == $past(branch_sum))
        else $error("Branch target wrong");
    a_push_top: assert property (@(posedge clk) disable iff (rst)
        is_push |=> stack_reg[0] == $past(pc_inc) && stack_reg[1] == $past(stack_reg[0]))
        else $error("Push did not shift stack");
    a_depth_sat: assert property (@(posedge clk) disable iff (rst)
        depth_reg <= 3'd6)
        else $error("Stack depth above six");
    a_pop_empty: assert property (@(posedge clk) disable iff (rst)
        is_pop && depth_reg == 3'd0 |=> depth_reg == 3'd0 && pc == $past(pc) + 12'h001)
        else $error("Empty return misbehaved");
    a_pop_load: assert property (@(posedge clk) disable iff (rst)
        is_pop && depth_reg != 3'd0 |=> pc == $past(stack_reg[0]) && depth_reg == $past(depth_reg) - 3'd1)
        else $error("Return did not pop stack");
    a_irq_enter: assert property (@(posedge clk) disable iff (rst)
        cyc_en && pc_op == PCOP_IRQ && ctx == CTX_MAIN |=> ctx == CTX_IRQ ##0 pc == $past(irq_vector))
        else $error("Interrupt entry wrong");
    a_flag_keep: assert property (@(posedge clk) disable iff (rst)
        ctx != CTX_MAIN |=> flags_reg[0] == $past(flags_reg[0]))
        else $error("Inactive pair changed");
    a_cycle_gap: assert property (@(posedge clk) disable iff (rst)
        cyc_en |=> !cyc_en [*8])
        else $error("CPU cycle too frequent");

    c_overflow: cover property (@(posedge clk) disable iff (rst) is_push && depth_reg == 3'd6);
    c_empty_ret: cover property (@(posedge clk) disable iff (rst) is_pop && depth_reg == 3'd0);
    c_return_from_interrupt_main: cover property (@(posedge clk) disable iff (rst)
        cyc_en && pc_op == PCOP_RETURN_FROM_INTERRUPT && ctx == CTX_NMI ##1 ctx == CTX_MAIN);

endmodule

// ---- tb/cpfs_seq_model.sv ----
`timescale 1ns/1ps

module cpfs_seq_model
    import cpfs_pkg::*;
(
    // Clock and cycle
    input  wire logic       clk,
    input  wire logic       cpu_cycle,
    // Requests to the core
    output cpfs_pcop_t      pc_op,
    output logic [7:0]      branch_offset,
    output logic [PC_W-1:0] irq_vector,
    output logic [PC_W-1:0] nmi_vector,
    output cpfs_flag_upd_t  flag_upd
);
    initial
    begin
        pc_op = PCOP_HOLD;
        branch_offset = 8'h00;
        irq_vector = 12'h000;
        nmi_vector = 12'h000;
        flag_upd = 4'h0;
    end

    // Held until just past the next sampling edge, so that edge never sees it move
    task automatic step(input cpfs_pcop_t op, input logic [7:0] off,
                        input logic [11:0] vec, input cpfs_flag_upd_t upd);
        pc_op = op;
        branch_offset = off;
        irq_vector = vec;
        nmi_vector = vec;
        flag_upd = upd;
        @(posedge clk);
        #1;
        while (cpu_cycle !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
    endtask
endmodule

// ---- tb/test_cpu_pc_flags_stack.sv ----
`timescale 1ns/1ps

module test_cpu_pc_flags_stack
    import cpfs_pkg::*;
;
    typedef struct packed {
        cpfs_pcop_t  op;
        logic [7:0]  off;
        logic [11:0] vec;
        logic [11:0] pc;
        cpfs_ctx_t   ctx;
        logic [2:0]  dep;
    } cpfs_row_t;

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            page_we = 1'b0;
    logic [3:0]      page_wdata = 4'h0;
    cpfs_pcop_t      pc_op;
    logic [7:0]      branch_offset;
    logic [11:0]     irq_vector;
    logic [11:0]     nmi_vector;
    cpfs_flag_upd_t  flag_upd;
    logic [11:0]     pc;
    logic [3:0]      prog_page;
    cpfs_flags_t     cur_flags;
    cpfs_ctx_t       ctx;
    logic [2:0]      stack_depth;
    logic            cpu_cycle;
    int              err_count = 0;
    int              n_tests = 0;
    int              n;
    cpfs_row_t       rows [11] = '{
        '{PCOP_INC, 8'h00, 12'h000, 12'hfff, CTX_NMI, 3'h0},
        '{PCOP_INC, 8'h00, 12'h000, 12'h000, CTX_NMI, 3'h0},
        '{PCOP_BRANCH, 8'h05, 12'h000, 12'h005, CTX_NMI, 3'h0},
        '{PCOP_BRANCH, 8'hfd, 12'h000, 12'h002, CTX_NMI, 3'h0},
        '{PCOP_RETURN_FROM_INTERRUPT, 8'h00, 12'h000, 12'h003, CTX_MAIN, 3'h0},
        '{PCOP_CALL, 8'h00, 12'h100, 12'h100, CTX_MAIN, 3'h1},
        '{PCOP_IRQ, 8'h00, 12'h200, 12'h200, CTX_IRQ, 3'h2},
        '{PCOP_NMI, 8'h00, 12'h300, 12'h300, CTX_NMI, 3'h3},
        '{PCOP_RETURN_FROM_INTERRUPT, 8'h00, 12'h000, 12'h201, CTX_IRQ, 3'h2},
        '{PCOP_RETURN_FROM_INTERRUPT, 8'h00, 12'h000, 12'h101, CTX_MAIN, 3'h1},
        '{PCOP_RET, 8'h00, 12'h000, 12'h004, CTX_MAIN, 3'h0}};

    always #25 clk = ~clk;

    cpfs_seq_model i_seq (.clk(clk), .cpu_cycle(cpu_cycle), .pc_op(pc_op), .branch_offset(branch_offset),
        .irq_vector(irq_vector), .nmi_vector(nmi_vector), .flag_upd(flag_upd));

    cpfs_core_state i_dut (.clk(clk), .rst(rst), .pc_op(pc_op), .branch_offset(branch_offset),
        .irq_vector(irq_vector), .nmi_vector(nmi_vector), .page_we(page_we), .page_wdata(page_wdata),
        .flag_upd(flag_upd), .pc(pc), .prog_page(prog_page), .cur_flags(cur_flags), .ctx(ctx),
        .stack_depth(stack_depth), .cpu_cycle(cpu_cycle));

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_state(input logic [11:0] epc, input cpfs_ctx_t ectx, input logic [2:0] edep);
        chk("pc", epc, pc);
        chk("ctx", {10'h000, ectx}, {10'h000, ctx});
        chk("depth", {9'h000, edep}, {9'h000, stack_depth});
    endtask

    // Flags lag the bank by one clock
    task automatic chk_flags(input logic [1:0] ef);
        @(posedge clk);
        #1;
        chk("flags", {10'h000, ef}, {10'h000, cur_flags});
    endtask

    task automatic do_reset;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk_state(12'hffe, CTX_NMI, 3'h0);
        chk("page", 12'h000, {8'h00, prog_page});
        chk("flags", 12'h000, {10'h000, cur_flags});
        rst = 1'b0;
        $display("Test reset done");
    endtask

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("Error watchdog expected done seen timeout");
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        do_reset();
        i_seq.step(PCOP_HOLD, 8'h00, 12'h000, 4'he);
        chk_flags(2'b10);
        i_seq.step(PCOP_RETURN_FROM_INTERRUPT, 8'h00, 12'h000, 4'h0);
        chk_state(12'hfff, CTX_MAIN, 3'h0);
        chk_flags(2'b00);
        i_seq.step(PCOP_HOLD, 8'h00, 12'h000, 4'h3);
        chk_flags(2'b01);
        i_seq.step(PCOP_IRQ, 8'h00, 12'h0a0, 4'h0);
        chk_state(12'h0a0, CTX_IRQ, 3'h1);
        chk_flags(2'b00);
        i_seq.step(PCOP_HOLD, 8'h00, 12'h000, 4'he);
        i_seq.step(PCOP_RETURN_FROM_INTERRUPT, 8'h00, 12'h000, 4'h0);
        chk_state(12'h000, CTX_MAIN, 3'h0);
        chk_flags(2'b01);
        i_seq.step(PCOP_NMI, 8'h00, 12'h0b0, 4'h0);
        chk_flags(2'b10);
        i_seq.step(PCOP_HOLD, 8'h00, 12'h000, 4'ha);
        chk_flags(2'b00);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (cpu_cycle !== 1'b1 && n < 40);
        // One clock of the period was already spent inside the flag check
        chk("cycle", 12'(CPU_DIV - 1), 12'(n));
        $display("Test flags done");
        page_wdata = 4'ha;
        page_we = 1'b1;
        @(posedge clk);
        #1;
        page_we = 1'b0;
        chk("page", 12'h00a, {8'h00, prog_page});
        do_reset();
        foreach (rows[i])
        begin
            i_seq.step(rows[i].op, rows[i].off, rows[i].vec, 4'h0);
            chk_state(rows[i].pc, rows[i].ctx, rows[i].dep);
        end
        $display("Test rows done");
        // Seven calls: the first return address must fall off the bottom
        for (int i = 0; i < 7; i++)
        begin
            i_seq.step(PCOP_CALL, 8'h00, 12'(12'h400 + i), 4'h0);
            chk_state(12'(12'h400 + i), CTX_MAIN, 3'(i < 6 ? i + 1 : 6));
        end
        for (int i = 0; i < 6; i++)
        begin
            i_seq.step(PCOP_RET, 8'h00, 12'h000, 4'h0);
            chk_state(12'(12'h406 - i), CTX_MAIN, 3'(5 - i));
        end
        i_seq.step(PCOP_RET, 8'h00, 12'h000, 4'h0);
        chk_state(12'h402, CTX_MAIN, 3'h0);
        $display("Test stack done");
        report_and_stop();
    end
endmodule
